// >>> hw/arb_pkg.sv
// Shared constants and helpers for the shared-bus arbitration node.
package arb_pkg;

    // Number of processor bus-request lines and width of an identity.
    localparam int NUM_REQ = 6;
    localparam int ID_W = 3;
    // Number of internal processors with their own host chip select.
    localparam int NUM_PROC = 4;
    // Flip-flops in each pin synchroniser.
    localparam int SYNC_STAGES = 2;

    // Values after reset.
    localparam logic [ID_W-1:0] MASTER_RST = 3'h0;
    localparam logic [ID_W-1:0] LAST_RST = 3'h0;
    localparam logic GRANT_RST = 1'h0;
    localparam logic [NUM_REQ-1:0] REQ_PIN_RST = 6'h3F;

    // Arbitration states, one-hot.
    typedef enum logic [2:0] {
        ST_SLAVE = 3'h1,
        ST_MASTER = 3'h2,
        ST_HOST = 3'h4
    } arb_state_t;

    // Identity to one-hot request line; identity zero selects no line.
    function automatic logic [NUM_REQ-1:0] id_onehot(
        input logic [ID_W-1:0] id
    );
        logic [NUM_REQ-1:0] v;
        v = 6'h00;
        if (id != 3'h0 && id <= 3'h6)
        begin
            v[id - 3'h1] = 1'b1;
        end
        return v;
    endfunction

endpackage

// >>> hw/arb_pick.sv
// Priority picker choosing the next bus master among active requesters.
`timescale 1ns/100ps
module arb_pick
    import arb_pkg::*;
(
    // Active-high request per line, bit 0 is identity 1.
    input wire logic [NUM_REQ-1:0] req,
    // Identity of the previous master, zero if none yet.
    input wire logic [ID_W-1:0] last_id,
    input wire logic rotate,
    // Winning identity, zero when nobody requests.
    output logic [ID_W-1:0] winner
);

    logic [ID_W-1:0] start;

    // Fixed priority starts at identity 1; rotating starts just past the
    // previous master so that it ends up lowest.
    always_comb
    begin
        logic [ID_W:0] pos;
        pos = 4'h0;
        start = 3'h0;
        if (rotate && last_id != 3'h0 && last_id < 3'h6)
        begin
            start = last_id;
        end
        winner = 3'h0;
        for (int k = NUM_REQ - 1; k >= 0; k--)
        begin
            // One spare bit keeps the sum from wrapping before line six.
            pos = {1'b0, start} + 4'(k);
            if (pos >= 4'h6)
            begin
                pos = pos - 4'h6;
            end
            if (req[pos[ID_W-1:0]])
            begin
                winner = pos[ID_W-1:0] + 3'h1;
            end
        end
    end

endmodule

// >>> hw/bus_arb_node.sv
// Bus arbitration, host grant and host wait-acknowledge for one node.
`timescale 1ns/100ps
module bus_arb_node
    import arb_pkg::*;
(
    // Clock, reset and freeze.
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    // Identity straps and priority select.
    input wire logic [ID_W-1:0] processor_identity_inputs,
    input wire logic rotating_priority_select,
    // Processor request lines, active low, bit 0 is line 1.
    input wire logic [NUM_REQ-1:0] multiproc_bus_request_lines_in,
    output logic [NUM_REQ-1:0] multiproc_bus_request_lines_out,
    output logic [NUM_REQ-1:0] multiproc_bus_request_lines_oe,
    // Shared core priority line, open-drain, active low.
    input wire logic core_priority_access_in_n,
    output logic core_priority_access_out_n,
    output logic core_priority_access_oe,
    // Host request and grant, active low.
    input wire logic host_bus_request_n,
    input wire logic host_bus_grant_in_n,
    output logic host_bus_grant_out_n,
    output logic host_bus_grant_oe,
    // Host chip selects, active low, one per internal processor.
    input wire logic select_proc_a_n,
    input wire logic select_proc_b_n,
    input wire logic select_proc_c_n,
    input wire logic select_proc_d_n,
    // Host wait-acknowledge pin.
    output logic host_wait_ack_out,
    output logic host_wait_ack_oe,
    // Per-processor configuration and host access readiness.
    input wire logic [NUM_PROC-1:0] ack_active_drive_bit,
    input wire logic [NUM_PROC-1:0] host_access_ready,
    // Core side of this node.
    input wire logic want_bus,
    input wire logic core_needs_bus,
    input wire logic dma_only,
    // Status towards the core.
    output logic is_master,
    output logic bus_drive_en,
    output logic [ID_W-1:0] current_master
);

    localparam int SYNC_W = NUM_REQ + 2 + 1 + 1 + NUM_PROC;

    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [SYNC_W-1:0] pins_raw;
    logic [NUM_REQ-1:0] req_pin_s;
    logic rotating_priority_select_s;
    logic hbr_s;
    logic cpa_s;
    logic grant_in_s;
    logic [NUM_PROC-1:0] sel_s;

    logic [NUM_REQ-1:0] own_line;
    logic [NUM_REQ-1:0] req_active;
    logic own_req;
    logic cpa_other;
    logic [ID_W-1:0] winner;

    arb_state_t state_reg;
    arb_state_t state_next;
    logic [ID_W-1:0] master_reg;
    logic [ID_W-1:0] master_next;
    logic [ID_W-1:0] last_reg;
    logic [ID_W-1:0] last_next;
    logic grant_reg;
    logic grant_next;
    logic own_req_reg;
    logic cpa_drive_reg;
    logic [1:0] cpa_echo_reg;

    logic any_sel;
    logic sel_ready;
    logic sel_active_drive;

    // Every pin input except the identity straps crosses two flops before any logic looks at it.
    assign pins_raw = {multiproc_bus_request_lines_in,
                       rotating_priority_select, host_bus_request_n,
                       core_priority_access_in_n, host_bus_grant_in_n,
                       select_proc_d_n, select_proc_c_n,
                       select_proc_b_n, select_proc_a_n};

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_reg <= '1;
            sync2_reg <= '1;
        end
        else if (clk_en)
        begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
        end
    end

    assign req_pin_s = sync2_reg[SYNC_W-1 -: NUM_REQ];
    assign rotating_priority_select_s = sync2_reg[NUM_PROC + 3];
    assign hbr_s = ~sync2_reg[NUM_PROC + 2];
    assign cpa_s = ~sync2_reg[NUM_PROC + 1];
    assign grant_in_s = ~sync2_reg[NUM_PROC];
    assign sel_s = ~sync2_reg[NUM_PROC-1:0];

    // Only our own line is ever driven; the others are merely read.
    assign own_line = id_onehot(processor_identity_inputs);

    // The core priority line carries our own drive too. It reaches the
    // synchronised view two cycles late, so the mask is our drive delayed
    // by the same two cycles; a fresh master would otherwise see its own
    // stale claim and give the bus away.
    assign cpa_other = cpa_s && !cpa_echo_reg[1];

    // A master doing only background DMA backs off for a slave core.
    always_comb
    begin
        own_req = want_bus;
        if (state_reg == ST_MASTER && dma_only && cpa_other)
        begin
            own_req = 1'b0;
        end
    end

    // Our own request is taken straight from the register, not from the
    // delayed pin, so this node sees it two cycles before the other nodes do.
    assign req_active = (~req_pin_s & ~own_line)
                      | (own_line & {NUM_REQ{own_req_reg}});

    arb_pick u_pick (
        .req(req_active),
        .last_id(last_reg),
        .rotate(rotating_priority_select_s),
        .winner(winner)
    );

    // Arbitration: the master holds the bus while it requests; on release
    // the picker chooses the next master. A host request freezes the
    // choice while a master is set, and sends the master into the released state.
    always_comb
    begin
        state_next = state_reg;
        master_next = master_reg;
        last_next = last_reg;
        grant_next = 1'b0;
        if (master_reg == 3'h0 || !req_active[master_reg - 3'h1])
        begin
            if (!hbr_s || master_reg == 3'h0)
            begin
                master_next = winner;
                if (master_reg != 3'h0 && winner != master_reg)
                begin
                    last_next = master_reg;
                end
            end
        end
        case (state_reg)
            ST_SLAVE:
            begin
                // A slave also waits until the host grant is seen released.
                if (master_next == processor_identity_inputs
                    && master_next != 3'h0 && !hbr_s
                    && !grant_in_s)
                begin
                    state_next = ST_MASTER;
                end
            end
            ST_MASTER:
            begin
                if (hbr_s)
                begin
                    state_next = ST_HOST;
                end
                else if (master_next != processor_identity_inputs)
                begin
                    state_next = ST_SLAVE;
                end
            end
            ST_HOST:
            begin
                // Drivers were released on entry; grant follows one
                // cycle later and stays until the host lets go.
                grant_next = hbr_s;
                if (!hbr_s)
                begin
                    state_next = (master_next == processor_identity_inputs)
                               ? ST_MASTER : ST_SLAVE;
                end
            end
            default:
            begin
                state_next = ST_SLAVE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= ST_SLAVE;
            master_reg <= MASTER_RST;
            last_reg <= LAST_RST;
            grant_reg <= GRANT_RST;
            own_req_reg <= 1'b0;
            cpa_drive_reg <= 1'b0;
            cpa_echo_reg <= 2'h0;
        end
        else if (clk_en)
        begin
            state_reg <= state_next;
            master_reg <= master_next;
            last_reg <= last_next;
            grant_reg <= grant_next;
            own_req_reg <= own_req;
            cpa_drive_reg <= core_needs_bus && state_reg != ST_MASTER;
            cpa_echo_reg <= {cpa_echo_reg[0], cpa_drive_reg};
        end
    end

    // Request line pin: driven low to request and high otherwise, on our own line only.
    assign multiproc_bus_request_lines_out = ~(own_line
                                             & {NUM_REQ{own_req_reg}});
    assign multiproc_bus_request_lines_oe = own_line;

    // Core priority: a slave core pulls the shared line low.
    assign core_priority_access_out_n = 1'b0;
    assign core_priority_access_oe = cpa_drive_reg;

    // Grant pin is driven by the bus master only; others just watch it.
    assign host_bus_grant_out_n = ~grant_reg;
    assign host_bus_grant_oe = (state_reg == ST_HOST);

    // Wait-acknowledge uses the selected processor's settings; the host
    // asserts one select at a time, so a plain OR picks the right one.
    always_comb
    begin
        any_sel = |sel_s;
        sel_ready = |(sel_s & host_access_ready);
        sel_active_drive = |(sel_s & ack_active_drive_bit);
    end

    // Low adds wait states; high is only driven in active-drive mode,
    // otherwise the pull-up supplies it.
    assign host_wait_ack_out = sel_ready;
    assign host_wait_ack_oe = any_sel && hbr_s
                            && (!sel_ready || sel_active_drive);

    // Status outputs; the bus drivers are off in the released state.
    assign is_master = (state_reg == ST_MASTER);
    assign bus_drive_en = (state_reg == ST_MASTER);
    assign current_master = master_reg;

endmodule

// >>> testbench/bus_arb_node_assertions.sv
// Property checker for the bus arbitration node.
`timescale 1ns/100ps
module arb_chk
    import arb_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Arbitration.
    input wire logic [ID_W-1:0] processor_identity_inputs,
    input wire logic [NUM_REQ-1:0] multiproc_bus_request_lines_oe,
    input wire logic is_master,
    input wire logic bus_drive_en,
    input wire logic [ID_W-1:0] current_master,
    input wire logic core_needs_bus,
    input wire logic core_priority_access_out_n,
    input wire logic core_priority_access_oe,
    // Host side.
    input wire logic host_bus_request_n,
    input wire logic host_bus_grant_oe,
    input wire logic host_wait_ack_out,
    input wire logic host_wait_ack_oe,
    input wire logic [NUM_PROC-1:0] ack_active_drive_bit,
    input wire logic [NUM_PROC-1:0] host_access_ready
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_req_own_line:
        assert property (multiproc_bus_request_lines_oe ==
            (processor_identity_inputs inside {[3'h1:3'h6]} ?
            6'h01 << (processor_identity_inputs - 3'h1) : 6'h00))
        else $error("request enable off own line");
    a_master_own_id:
        assert property (is_master |-> current_master ==
            processor_identity_inputs)
        else $error("master identity wrong");
    a_ack_needs_host:
        assert property (host_wait_ack_oe |-> !$past(host_bus_request_n, 2))
        else $error("acknowledge driven without host request");
    a_ack_wait_low:
        assert property (host_wait_ack_oe && host_access_ready == 4'h0
            |-> !host_wait_ack_out)
        else $error("no wait while not ready");
    a_ack_open_drain:
        assert property (host_wait_ack_oe && ack_active_drive_bit == 4'h0
            |-> !host_wait_ack_out)
        else $error("open-drain acknowledge driven high");
    a_host_release:
        assert property (!host_bus_request_n [*5] |-> !bus_drive_en)
        else $error("bus kept during host request");
    a_grant_hold:
        assert property (host_bus_grant_oe && !host_bus_request_n
            |=> host_bus_grant_oe)
        else $error("grant dropped while host requests");
    a_grant_drive_off:
        assert property (host_bus_grant_oe |-> !bus_drive_en)
        else $error("grant while bus still driven");
    a_core_pri_drive:
        assert property (core_priority_access_oe |->
            !core_priority_access_out_n && $past(core_needs_bus))
        else $error("core priority driven without need");
endmodule

bind bus_arb_node arb_chk i_arb_chk (.clk, .rst,
    .processor_identity_inputs, .multiproc_bus_request_lines_oe,
    .is_master, .bus_drive_en, .current_master, .core_needs_bus,
    .core_priority_access_out_n, .core_priority_access_oe,
    .host_bus_request_n, .host_bus_grant_oe, .host_wait_ack_out,
    .host_wait_ack_oe, .ack_active_drive_bit, .host_access_ready);

// >>> testbench/bus_peers.sv
// Peer processors and board pulls on the shared request lines.
`timescale 1ns/100ps
module bus_peers
    import arb_pkg::*;
(
    // Node pin drivers.
    input wire logic [NUM_REQ-1:0] node_out,
    input wire logic [NUM_REQ-1:0] node_oe,
    input wire logic node_cpa_oe,
    // Peers asking for the bus, one bit per line.
    input wire logic [NUM_REQ-1:0] peer_req,
    // A peer slave core claiming core priority.
    input wire logic peer_cpa,
    // Resolved wires.
    output logic [NUM_REQ-1:0] req_lines,
    output logic cpa_line_n
);
    // Idle peers drive their line high; empty lines rest on a pull-up.
    always_comb
    begin
        for (int i = 0; i < NUM_REQ; i++)
            req_lines[i] = node_oe[i] ? node_out[i] : !peer_req[i];
    end
    // Open-drain priority line with its pull-up.
    assign cpa_line_n = !(node_cpa_oe || peer_cpa);
endmodule

// >>> testbench/bus_arb_node_tb_top.sv
// Self-checking bench for the bus arbitration node.
`timescale 1ns/100ps
module bus_arb_node_tb_top;
    import arb_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic want = 1'b0;
    logic needs = 1'b0;
    logic rps = 1'b0;
    logic hbr_n = 1'b1;
    logic [3:0] sel_n = 4'hF;
    logic [3:0] ad_bit = 4'h0;
    logic [3:0] rdy = 4'h0;
    logic [5:0] peer_req = 6'h00;
    logic dma = 1'b0;
    logic peer_cpa = 1'b0;
    logic [5:0] lines, l_out, l_oe;
    logic cpa_n, cpa_out_n, cpa_oe, g_out_n, g_oe, ack_out, ack_oe, is_m, drv;
    logic [2:0] cur;
    int error_cnt = 0;
    int num_checks = 0;
    int cycles = 0;

    // Clock of 4 ns.
    always #2 clk = ~clk;

    // Hang guard; the tests need about 80 cycles.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            error_cnt++;
            end_sim();
        end
    end

    bus_arb_node i_bus_arb_node (.clk(clk), .rst(rst), .clk_en(1'b1),
        .processor_identity_inputs(3'h2), .rotating_priority_select(rps),
        .multiproc_bus_request_lines_in(lines),
        .multiproc_bus_request_lines_out(l_out),
        .multiproc_bus_request_lines_oe(l_oe),
        .core_priority_access_in_n(cpa_n),
        .core_priority_access_out_n(cpa_out_n),
        .core_priority_access_oe(cpa_oe), .host_bus_request_n(hbr_n),
        .host_bus_grant_in_n(g_oe ? g_out_n : 1'b1),
        .host_bus_grant_out_n(g_out_n), .host_bus_grant_oe(g_oe),
        .select_proc_a_n(sel_n[0]), .select_proc_b_n(sel_n[1]),
        .select_proc_c_n(sel_n[2]), .select_proc_d_n(sel_n[3]),
        .host_wait_ack_out(ack_out), .host_wait_ack_oe(ack_oe),
        .ack_active_drive_bit(ad_bit), .host_access_ready(rdy),
        .want_bus(want), .core_needs_bus(needs), .dma_only(dma),
        .is_master(is_m), .bus_drive_en(drv), .current_master(cur));

    bus_peers i_bus_peers (.node_out(l_out), .node_oe(l_oe),
        .node_cpa_oe(cpa_oe), .peer_req(peer_req), .peer_cpa(peer_cpa),
        .req_lines(lines),
        .cpa_line_n(cpa_n));

    // Compare and count; an unknown never matches.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Inputs change 1 ns after the edge so no race with sampling.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Host pins: bus request and one chip select at most.
    task automatic host(input logic req_n, input logic [3:0] s_n);
        hbr_n = req_n;
        sel_n = s_n;
    endtask

    // Core side requests.
    task automatic core(input logic w, input logic n);
        want = w;
        needs = n;
    endtask

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Main sequence: fixed then rotating arbitration, then a host access.
    initial
    begin
        cyc(6);
        rst = 1'b0;
        cyc(1);
        chk(l_oe, 8'h02);
        chk({g_oe, ack_oe, is_m}, 8'h00);
        for (int m = 0; m < 2; m++)
        begin
            rps = m[0];
            core(1'b1, 1'b0);
            cyc(4);
            chk({is_m, drv, cur}, 8'h1A);
            peer_req = 6'h05;
            cyc(6);
            chk({is_m, l_out[1]}, 8'h02);
            core(1'b0, 1'b1);
            cyc(6);
            chk(cur, m ? 8'h03 : 8'h01);
            chk({cpa_oe, is_m}, 8'h02);
            core(1'b0, 1'b0);
            peer_req = 6'h00;
            cyc(6);
        end
        core(1'b1, 1'b0);
        cyc(4);
        // A peer core's priority claim makes a DMA-only master let go.
        dma = 1'b1;
        peer_req = 6'h01;
        peer_cpa = 1'b1;
        cyc(6);
        chk({is_m, cur}, 8'h01);
        dma = 1'b0;
        peer_req = 6'h00;
        peer_cpa = 1'b0;
        cyc(6);
        chk({is_m, cur}, 8'h0A);
        host(1'b0, 4'hD);
        cyc(4);
        chk({drv, g_oe}, 8'h01);
        cyc(1);
        chk(g_out_n, 8'h00);
        chk({ack_oe, ack_out}, 8'h02);
        rdy = 4'hF;
        cyc(1);
        chk(ack_oe, 8'h00);
        ad_bit = 4'h2;
        cyc(1);
        chk({ack_oe, ack_out}, 8'h03);
        host(1'b0, 4'hF);
        cyc(3);
        chk({ack_oe, g_out_n}, 8'h00);
        host(1'b1, 4'hD);
        cyc(5);
        chk({ack_oe, g_oe, is_m}, 8'h01);
        end_sim();
    end
endmodule
